// *** shared/dffc_map.svh ***
// constants for the differential d flip-flop block
//
// Operation
// - each rising differential clock edge copies the data level onto the outputs
// - a swapped clock pair makes capture follow the falling edge of the original
// - an open or low-railed data pair captures as a differential low
// - an open or low-railed clock pair captures nothing; outputs hold their state
// - true output carries the stored bit, complement output always its inverse
// - data level is set by the difference of true and inverting inputs
// - outputs fed back crosswise to data make a divide-by-two toggle
`ifndef DFFC_MAP_SVH
`define DFFC_MAP_SVH

// ----------------------------------------
// synchroniser and reset values
// ----------------------------------------
`define DFFC_SYNC_STAGES 2
`define DFFC_PIN_COUNT 4
`define DFFC_Q_RST 1'b0
`define DFFC_VALID_RST 1'b0

// ----------------------------------------
// pin positions inside the synchronised word
// ----------------------------------------
`define DFFC_PIN_D_P 3
`define DFFC_PIN_D_N 2
`define DFFC_PIN_C_P 1
`define DFFC_PIN_C_N 0

`endif

// *** shared/dffc_pkg.sv ***
// types for the differential d flip-flop block
`default_nettype none

package dffc_pkg;

  // ----------------------------------------
  // differential pair
  // ----------------------------------------
  typedef struct packed {
    logic p;
    logic n;
  } dffc_pair_t;

  // ----------------------------------------
  // decoded clock pair state, gray along open, low, high
  // ----------------------------------------
  typedef enum logic [1:0] {
    DFFC_CK_OPEN = 2'h0,
    DFFC_CK_LOW = 2'h1,
    DFFC_CK_HIGH = 2'h3,
    DFFC_CK_BAD = 2'h2
  } dffc_ck_t;

endpackage

`default_nettype wire

// *** core/dffc_sync.sv ***
// two-stage synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none

module dffc_sync #(
  parameter int WIDTH = 4,
  parameter int STAGES = 2
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] sync
);

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("dffc_sync: width must be at least one");
  end
  if (STAGES != 2) begin : g_bad_stages
    $error("dffc_sync: exactly two stages are supported");
  end

  // ----------------------------------------
  // stages
  // ----------------------------------------
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync;

  always_comb begin
    next_meta = rst ? '0 : pin;
    next_sync = rst ? '0 : meta;
  end

  always_ff @(posedge mclk) begin
    meta <= next_meta;
    sync <= next_sync;
  end

endmodule

`default_nettype wire

// *** core/dffc_core.sv ***
// differential d flip-flop core
`timescale 1ns/1ps
`default_nettype none
`include "dffc_map.svh"

module dffc_core
  import dffc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire dffc_pair_t data_pin,
  input wire dffc_pair_t clk_pin,
  output dffc_pair_t q_pair,
  output logic q_valid,
  output logic capture
);

  // ----------------------------------------
  // decode functions
  // ----------------------------------------
  function automatic dffc_ck_t ck_decode(input dffc_pair_t pr);
    dffc_ck_t st;
    st = DFFC_CK_BAD;
    unique case ({pr.p, pr.n})
      2'b00: st = DFFC_CK_OPEN;
      2'b01: st = DFFC_CK_LOW;
      2'b10: st = DFFC_CK_HIGH;
      2'b11: st = DFFC_CK_BAD;
    endcase
    return st;
  endfunction

  // open, railed low or both high all read as low
  function automatic logic data_level(input dffc_pair_t pr);
    return pr.p & ~pr.n;
  endfunction

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  logic [`DFFC_PIN_COUNT-1:0] pin_raw;
  logic [`DFFC_PIN_COUNT-1:0] pin_sync;
  dffc_pair_t d_s;
  dffc_pair_t c_s;

  assign pin_raw = {data_pin.p, data_pin.n, clk_pin.p, clk_pin.n};

  dffc_sync #(
    .WIDTH(`DFFC_PIN_COUNT),
    .STAGES(`DFFC_SYNC_STAGES)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin(pin_raw),
    .sync(pin_sync)
  );

  assign d_s.p = pin_sync[`DFFC_PIN_D_P];
  assign d_s.n = pin_sync[`DFFC_PIN_D_N];
  assign c_s.p = pin_sync[`DFFC_PIN_C_P];
  assign c_s.n = pin_sync[`DFFC_PIN_C_N];

  // ----------------------------------------
  // clock pair tracking and edge detect
  // ----------------------------------------
  dffc_ck_t ck_state;
  dffc_ck_t next_ck_state;
  logic rise;
  logic d_lvl;

  always_comb begin
    next_ck_state = rst ? DFFC_CK_OPEN : ck_decode(c_s);
    // edge only from a driven low to a driven high; both pins must flip in the same sampled cycle
    rise = !rst && (ck_state == DFFC_CK_LOW) && (next_ck_state == DFFC_CK_HIGH);
    d_lvl = data_level(d_s);
  end

  always_ff @(posedge mclk) begin
    ck_state <= next_ck_state;
  end

  // ----------------------------------------
  // stored bit and outputs
  // ----------------------------------------
  logic q;
  logic q_inv;
  logic next_q;
  logic next_q_inv;
  logic next_valid;
  logic next_capture;

  always_comb begin
    next_q = q;
    next_valid = q_valid;
    next_capture = 1'b0;
    if (rst) begin
      next_q = `DFFC_Q_RST;
      next_valid = `DFFC_VALID_RST;
    end else if (rise) begin
      next_q = d_lvl;
      next_valid = 1'b1;
      next_capture = 1'b1;
    end
    // open clock never produces rise, so the bit holds
    next_q_inv = ~next_q;
  end

  always_ff @(posedge mclk) begin
    q <= next_q;
    q_inv <= next_q_inv;
    q_valid <= next_valid;
    capture <= next_capture;
  end

  assign q_pair.p = q;
  assign q_pair.n = q_inv;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_ck_low;
    !c_s.p && c_s.n;
  endsequence

  sequence s_ck_high;
    c_s.p && !c_s.n;
  endsequence

  sequence s_ck_open;
    !c_s.p && !c_s.n;
  endsequence

  a_rise_capture: assert property (
    @(posedge mclk) disable iff (rst)
    rise |=> (q_pair.p == $past(d_lvl)) && capture
  ) else $error("captured bit does not match data at clock edge");

  a_edge_from_pair: assert property (
    @(posedge mclk) disable iff (rst)
    !$past(rst) ##0 s_ck_low ##1 s_ck_high |-> rise
  ) else $error("low to high clock pair did not give an edge");

  a_open_data_low: assert property (
    @(posedge mclk) disable iff (rst)
    rise && !d_s.p && !d_s.n |=> !q_pair.p && q_pair.n
  ) else $error("open data pair did not capture low");

  a_open_clock_hold: assert property (
    @(posedge mclk) disable iff (rst)
    s_ck_open ##1 s_ck_open |-> !rise ##1 ($stable(q_pair) && !capture)
  ) else $error("outputs changed with clock pair open");

  a_outputs_complement: assert property (
    @(posedge mclk) disable iff (rst)
    q_pair.p != q_pair.n
  ) else $error("true and complement outputs agree");

  a_diff_decode: assert property (
    @(posedge mclk) disable iff (rst)
    rise && (d_s.p != d_s.n) |=> q_pair.p == $past(d_s.p)
  ) else $error("differential data decoded wrongly");

  a_toggle_feedback: assert property (
    @(posedge mclk) disable iff (rst)
    rise && (d_lvl == q_pair.n) |=> q_pair.p != $past(q_pair.p)
  ) else $error("fed back outputs did not toggle");

  a_valid_after_capture: assert property (
    @(posedge mclk) disable iff (rst)
    (!q_valid && !rise |=> !q_valid) and (rise |=> q_valid ##1 q_valid)
  ) else $error("valid flag does not follow first capture");

endmodule

`default_nettype wire

// *** dv/dffc_src.sv ***
// clock and data pin source model for the flip-flop
`timescale 1ns/1ps
`default_nettype none

module dffc_src
  import dffc_pkg::*;
(
  input wire logic ck,
  input wire logic [1:0] ck_mode,
  input wire logic d,
  input wire logic [1:0] d_mode,
  input wire dffc_pair_t q_pair,
  output dffc_pair_t clk_pin,
  output dffc_pair_t data_pin
);
  // open pins fall to the pull-down level
  always_comb begin
    case (ck_mode)
      2'h1: clk_pin = 2'h0;
      2'h2: clk_pin = {~ck, ck};
      default: clk_pin = {ck, ~ck};
    endcase
    case (d_mode)
      2'h1: data_pin = 2'h0;
      2'h2: data_pin = {q_pair.n, q_pair.p};
      2'h3: data_pin = 2'h3;
      default: data_pin = {d, ~d};
    endcase
  end
endmodule

`default_nettype wire

// *** dv/dffc_core_bench.sv ***
// self-checking bench for the differential flip-flop
`timescale 1ns/1ps
`default_nettype none

module dffc_core_bench;
  import dffc_pkg::*;
  logic mclk, rst, ck, d, e;
  logic [1:0] ck_mode, d_mode;
  dffc_pair_t clk_pin, data_pin, q_pair;
  logic q_valid, capture;
  int fail_count, n_checks, ncap, n;

  dffc_core i_dut (.mclk(mclk), .rst(rst), .data_pin(data_pin), .clk_pin(clk_pin),
    .q_pair(q_pair), .q_valid(q_valid), .capture(capture));
  dffc_src i_src (.ck(ck), .ck_mode(ck_mode), .d(d), .d_mode(d_mode), .q_pair(q_pair),
    .clk_pin(clk_pin), .data_pin(data_pin));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) if (capture === 1'b1) ncap++;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [1:0] seen, input logic [1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic pulse();
    ck = 1'b0;
    cyc(4);
    ck = 1'b1;
    cyc(5);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_data();
    for (int i = 0; i < 4; i++) begin
      d = 1'b1;
      d_mode = 2'h0;
      pulse();
      d = i[0];
      d_mode = i[1] ? (i[0] ? 2'h3 : 2'h1) : 2'h0;
      n = ncap;
      pulse();
      e = (i < 2) ? i[0] : 1'b0;
      check("q", q_pair, {e, ~e});
      check("cap", 2'(ncap - n), 2'h1);
      check("valid", {1'b0, q_valid}, 2'h1);
    end
  endtask
  task automatic t_open_clock();
    d = 1'b1;
    d_mode = 2'h0;
    ck = 1'b0;
    n = ncap;
    cyc(4);
    ck_mode = 2'h1;
    cyc(4);
    ck = 1'b1;
    d = 1'b0;
    cyc(2);
    d = 1'b1;
    ck_mode = 2'h0;
    cyc(5);
    check("hold", q_pair, 2'h1);
    check("nocap", 2'(ncap - n), 2'h0);
  endtask
  task automatic t_swap();
    ck_mode = 2'h2;
    cyc(4);
    ck = 1'b0;
    cyc(5);
    check("fall", q_pair, 2'h2);
    d = 1'b0;
    ck = 1'b1;
    cyc(5);
    check("rise", q_pair, 2'h2);
    ck = 1'b0;
    cyc(5);
    check("fall", q_pair, 2'h1);
    ck_mode = 2'h0;
  endtask
  task automatic t_toggle();
    d_mode = 2'h2;
    e = 1'b1;
    repeat (4) begin
      pulse();
      check("tog", q_pair, {e, ~e});
      e = ~e;
    end
  endtask
  task automatic t_reset();
    d = 1'b1;
    d_mode = 2'h0;
    rst = 1'b1;
    cyc(3);
    rst = 1'b0;
    cyc(1);
    check("rst_q", q_pair, 2'h1);
    check("rst_valid", {capture, q_valid}, 2'h0);
    pulse();
    check("rst_cap", q_pair, 2'h2);
    check("rst_valid", {1'b0, q_valid}, 2'h1);
  endtask

  initial begin
    rst = 1'b1;
    ck = 1'b0;
    d = 1'b0;
    ck_mode = 2'h0;
    d_mode = 2'h0;
    cyc(5);
    rst = 1'b0;
    cyc(1);
    check("valid", {capture, q_valid}, 2'h0);
    t_data();
    t_open_clock();
    t_swap();
    t_toggle();
    t_reset();
    report_and_stop();
  end
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule

`default_nettype wire
